// ==== inc/i2c_ctrl_consts.svh ====
// Purpose: timing counts, codes and reset values of the two-wire bus controller
// Assumes: core clock 10 ns, link clock 125 ns
// Notes: counts round least times up to whole cycles
`ifndef I2C_CTRL_CONSTS_SVH
`define I2C_CTRL_CONSTS_SVH
// ==========================================================
// clock periods and times
`define CORE_PERIOD_NS 10
`define LINK_PERIOD_NS 125
`define T_HALF_NS 2500
`define T_LOW_NS 5000
`define LRST_NS 500
// ==========================================================
// derived cycle counts
`define HALF_CYC (8'((`T_HALF_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS))
`define TLOW_CYC (8'((`T_LOW_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS))
`define LRST_CYC (8'((`LRST_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS))
// ==========================================================
// codes and reset values
`define MODE_I2C 2'h2
`define MODE_PORT 2'h0
`define SWR_FIRST 2'h2
`define SWR_SECOND 2'h1
`define CTL_START 4'hF
`define CTL_STOP 4'hD
`define BITS_FULL 4'h8
`define PIN_RST 1'h1
`endif

// ==== inc/i2c_ctrl_pkg.sv ====
// Purpose: types shared by the two-wire bus controller
// Assumes: nothing beyond SystemVerilog packed types
// Notes: field order of each struct is msb first
package i2c_ctrl_pkg;
   // ==========================================================
   // control write carrier
   typedef struct packed {
      logic master;
      logic transmit;
      logic busy;
      logic pending_n;
      logic [1:0] soft_init;
      logic [1:0] iface_mode;
   } cr2_wr_t;
   // ==========================================================
   // status carrier
   typedef struct packed {
      logic busy;
      logic master;
      logic transmit;
      logic pending_n;
      logic lost_arb;
      logic addressed;
      logic gcall;
      logic last_bit;
   } status_t;
   // ==========================================================
   // link event payload
   typedef struct packed {
      logic start_seen;
      logic stop_seen;
      logic lost;
      logic frame;
      logic irq;
      logic keep_pin;
      logic addr_phase;
      logic match;
      logic gcall;
      logic rw;
      logic master_select;
      logic last_bit;
      logic [7:0] data;
   } evt_t;
   // ==========================================================
   // configuration seen by the link side
   typedef struct packed {
      logic [7:0] txd;
      logic [6:0] own;
      logic free_fmt;
      logic ack_en;
      logic [2:0] bit_count;
      logic transmit;
   } link_cfg_t;
   // ==========================================================
   // master sequencer states
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_START = 3'b001,
      L_LOW = 3'b010,
      L_HIGH = 3'b011,
      L_HOLD = 3'b100,
      L_STOP1 = 3'b101,
      L_STOP2 = 3'b110,
      L_STOP3 = 3'b111
   } link_st_t;
endpackage

// ==== rtl/i2c_ctrl.sv ====
// Purpose: start/stop generation, service hold and status flags of a two-wire bus port
// Assumes: link_clk_i runs free; software inputs are on core_clk_i
// Notes: bus lines are only pulled low or released
// Contract
// R1: idle bus plus control write 1111 generates start, then sends address byte.
// R2: software enables the acknowledge clock before asking for a start.
// R3: busy bus plus control write 1101 generates a stop.
// R4: software leaves control bits alone until the stop appears.
// R5: stop waits until the clock line is released by others.
// R6: busy flag set on start seen, cleared on stop seen.
// R7: master interrupt after counted bits plus optional acknowledge clock.
// R8: slave interrupt after own or general address, and after each later byte.
// R9: address mode treats all-zero first byte as general call.
// R10: interrupt clears service bit; clock held low while it stays zero.
// R11: data buffer access sets service bit; clock released after low time.
// R12: software writes one to set service bit; zero does nothing.
// R13: after lost arbitration with no match, service bit stays set.
// R14: start asked on busy bus loses arbitration, no start driven.
// R15: master compares sent and seen data at each clock rise.
// R16: arbitration loss drops master and transmit, releases lines.
// R17: lost flag cleared by data access or control write.
// R18: addressed flag set on match/general call or first free byte; cleared by access.
// R19: general call flag set by zero first byte, cleared on start or stop; code also sets it on any later zero byte received while not master.
// R20: last bit holds data level at each clock rise.
// R21: idle run enable decides whether the port runs in idle mode.
// R22: soft init 10 then 01 in bus mode resets all and returns to port mode.
// R23: first byte after start is always eight bits.
// R24: master adds an acknowledge clock when enabled.
// R25: both lines only pulled low or released.
`timescale 1ns/1ns
`include "i2c_ctrl_consts.svh"
module i2c_ctrl (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic link_clk_i,
   input wire logic cr2_wr_i,
   input wire i2c_ctrl_pkg::cr2_wr_t cr2_wdata_i,
   input wire logic dbr_wr_i,
   input wire logic [7:0] dbr_wdata_i,
   input wire logic dbr_rd_i,
   input wire logic ack_en_i,
   input wire logic [2:0] bit_count_i,
   input wire logic [6:0] own_addr_i,
   input wire logic free_format_i,
   input wire logic idle_run_en_i,
   input wire logic idle_mode_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   output logic sda_o,
   output logic sda_oe_n_o,
   output i2c_ctrl_pkg::status_t status_o,
   output logic [7:0] rx_data_o,
   output logic [1:0] soft_init_o,
   output logic [1:0] iface_mode_o,
   output logic irq_o
);
   import i2c_ctrl_pkg::*;

   // ==========================================================
   // core side registers
   logic mst_ff, trx_ff, bb_ff, pin_ff, al_ff, aas_ff, ado_ff, irq_ff;
   logic [7:0] rxd_ff, txd_ff, lrst_cnt_ff;
   logic [1:0] swr_ff, mode_ff, lrb_sync_ff;
   logic swr_seq_ff, lrst_ff, start_tgl_ff, stop_tgl_ff, resume_tgl_ff;
   logic [2:0] evt_sync_ff;
   // link side registers
   evt_t evt_ff;
   logic evt_tgl_ff;
   link_st_t st_ff;
   logic [7:0] ph_ff, rel_cnt_ff;
   logic [3:0] cnt_ff;
   logic [7:0] sh_ff;
   logic scl_q_ff, sda_q_ff, busy_l_ff, mst_l_ff, addr_ph_ff, sel_ff, slv_tx_ff;
   logic lostf_ff, hold_ff, lrb_l_ff, start_req_ff, stop_req_ff;
   logic scl_oe_n_ff, sda_oe_n_ff, zero_ff;
   logic [2:0] tgl_q_ff;

   // ==========================================================
   // core decode
   wire [3:0] cr2_ctl = {cr2_wdata_i.master, cr2_wdata_i.transmit,
                         cr2_wdata_i.busy, cr2_wdata_i.pending_n};
   wire start_wr = cr2_wr_i & (cr2_ctl == `CTL_START);
   wire stop_wr = cr2_wr_i & (cr2_ctl == `CTL_STOP) & bb_ff;
   wire dbr_acc = dbr_wr_i | dbr_rd_i;
   wire evt_hit = evt_sync_ff[2] ^ evt_sync_ff[1];
   wire srst_now = cr2_wr_i & swr_seq_ff & (cr2_wdata_i.soft_init == `SWR_SECOND)
                   & (cr2_wdata_i.iface_mode == `MODE_I2C);
   wire clr = rst_i | srst_now;
   wire run = (mode_ff == `MODE_I2C) & ~(idle_mode_i & ~idle_run_en_i); // R21
   wire pin_hw_clr = evt_hit & evt_ff.frame & evt_ff.irq & ~evt_ff.keep_pin;
   wire pin_sw_set = dbr_acc | (cr2_wr_i & cr2_wdata_i.pending_n);

   // soft reset sequence and mode fields
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         swr_seq_ff <= 1'b0;
         swr_ff <= 2'h0; // R22
         mode_ff <= `MODE_PORT; // R22
      end else if (cr2_wr_i) begin
         swr_seq_ff <= (cr2_wdata_i.soft_init == `SWR_FIRST)
                       & (cr2_wdata_i.iface_mode == `MODE_I2C);
         swr_ff <= cr2_wdata_i.soft_init;
         mode_ff <= cr2_wdata_i.iface_mode;
      end
   end

   // link reset stretched to be seen by the slow clock
   always_ff @(posedge core_clk_i) begin
      if (clr | ~run) begin
         lrst_cnt_ff <= `LRST_CYC;
         lrst_ff <= 1'b1;
      end else begin
         if (lrst_cnt_ff != 8'h00) lrst_cnt_ff <= lrst_cnt_ff - 8'h01;
         lrst_ff <= (lrst_cnt_ff != 8'h00);
      end
   end

   // event toggle and last-bit level from the link side
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         evt_sync_ff <= 3'h0;
         lrb_sync_ff <= 2'h0;
      end else begin
         evt_sync_ff <= {evt_sync_ff[1:0], evt_tgl_ff};
         lrb_sync_ff <= {lrb_sync_ff[0], lrb_l_ff}; // R20
      end
   end

   // master and transmit selection
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         mst_ff <= 1'b0;
         trx_ff <= 1'b0;
      end else if (evt_hit & (evt_ff.stop_seen | evt_ff.lost)) begin
         mst_ff <= 1'b0; // R16
         trx_ff <= 1'b0;
      end else if (start_wr & bb_ff) begin
         mst_ff <= 1'b0; // R14
         trx_ff <= 1'b0;
      end else if (cr2_wr_i) begin
         mst_ff <= cr2_wdata_i.master;
         trx_ff <= cr2_wdata_i.transmit;
      end else if (evt_hit & evt_ff.frame & evt_ff.addr_phase & ~free_format_i) begin
         if (evt_ff.master_select & ~evt_ff.last_bit) trx_ff <= ~evt_ff.rw;
         else if (~evt_ff.master_select & (evt_ff.match | evt_ff.gcall)) trx_ff <= evt_ff.rw;
      end
   end

   // bus busy flag
   always_ff @(posedge core_clk_i) begin
      if (clr) bb_ff <= 1'b0;
      else if (evt_hit & evt_ff.start_seen) bb_ff <= 1'b1; // R6
      else if (evt_hit & evt_ff.stop_seen) bb_ff <= 1'b0; // R6
   end

   // service pending bit and resume toggle
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         pin_ff <= `PIN_RST;
         resume_tgl_ff <= 1'b0;
      end else if (pin_hw_clr) begin
         pin_ff <= 1'b0; // R10
      end else if (pin_sw_set) begin
         pin_ff <= 1'b1; // R11 R12
         if (~pin_ff) resume_tgl_ff <= ~resume_tgl_ff; // R11
      end
   end

   // start and stop requests
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         start_tgl_ff <= 1'b0;
         stop_tgl_ff <= 1'b0;
      end else begin
         if (start_wr & ~bb_ff) start_tgl_ff <= ~start_tgl_ff; // R1
         if (stop_wr) stop_tgl_ff <= ~stop_tgl_ff; // R3
      end
   end

   // arbitration lost flag, set wins over clear
   always_ff @(posedge core_clk_i) begin
      if (clr) al_ff <= 1'b0;
      else if ((evt_hit & evt_ff.lost) | (start_wr & bb_ff)) al_ff <= 1'b1; // R14 R15
      else if (dbr_acc | cr2_wr_i) al_ff <= 1'b0; // R17
   end

   // addressed and general call flags
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         aas_ff <= 1'b0;
         ado_ff <= 1'b0;
      end else begin
         if (evt_hit & evt_ff.frame & ~evt_ff.master_select & evt_ff.addr_phase
             & (free_format_i | evt_ff.match | evt_ff.gcall)) aas_ff <= 1'b1; // R18
         else if (dbr_acc) aas_ff <= 1'b0; // R18
         if (evt_hit & evt_ff.frame & ~evt_ff.master_select & evt_ff.gcall) ado_ff <= 1'b1; // R19
         else if (evt_hit & (evt_ff.start_seen | evt_ff.stop_seen)) ado_ff <= 1'b0; // R19
      end
   end

   // data buffers and interrupt pulse
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         rxd_ff <= 8'h00;
         txd_ff <= 8'h00;
         irq_ff <= 1'b0;
      end else begin
         if (evt_hit & evt_ff.frame) rxd_ff <= evt_ff.data;
         if (dbr_wr_i) txd_ff <= dbr_wdata_i;
         irq_ff <= evt_hit & evt_ff.frame & evt_ff.irq; // R7 R8
      end
   end

   assign status_o = {bb_ff, mst_ff, trx_ff, pin_ff, al_ff, aas_ff, ado_ff, lrb_sync_ff[1]};
   assign rx_data_o = rxd_ff;
   assign soft_init_o = swr_ff;
   assign iface_mode_o = mode_ff;
   assign irq_o = irq_ff;

   // ==========================================================
   // link side: two-stage synchronisers for pins and core levels
   link_cfg_t cfg_c;
   assign cfg_c = '{txd: txd_ff, own: own_addr_i, free_fmt: free_format_i,
                    ack_en: ack_en_i, bit_count: bit_count_i, transmit: trx_ff};
   localparam int XW = $bits(link_cfg_t) + 6;
   wire [XW-1:0] x_in = {scl_i, sda_i, start_tgl_ff, stop_tgl_ff, resume_tgl_ff,
                         lrst_ff, cfg_c};
   wire [XW-1:0] x_s;
   genvar gi;
   generate
      for (gi = 0; gi < XW; gi++) begin : g_sync
         logic s1_ff, s2_ff;
         always_ff @(posedge link_clk_i) begin
            s1_ff <= x_in[gi];
            s2_ff <= s1_ff;
         end
         assign x_s[gi] = s2_ff;
      end
   endgenerate

   link_cfg_t cfg_s;
   assign cfg_s = x_s[$bits(link_cfg_t)-1:0];
   wire lr = x_s[XW-6];
   wire resume_s = x_s[XW-5];
   wire stop_s = x_s[XW-4];
   wire start_s = x_s[XW-3];
   wire sda_s = x_s[XW-2];
   wire scl_s = x_s[XW-1];

   // bus condition monitor
   wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   wire stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
   wire scl_rise = scl_s & ~scl_q_ff;
   wire scl_fall = ~scl_s & scl_q_ff;
   wire res_edge = resume_s ^ tgl_q_ff[0];
   wire [3:0] nb = (addr_ph_ff | (cfg_s.bit_count == 3'h0)) ? `BITS_FULL
                   : {1'b0, cfg_s.bit_count}; // R23
   wire ack_clk = mst_l_ff ? cfg_s.ack_en : 1'b1; // R24
   wire [3:0] total = nb + {3'h0, ack_clk};
   wire match = ~cfg_s.free_fmt & (sh_ff[7:1] == cfg_s.own);
   wire gcall = ~cfg_s.free_fmt & (sh_ff == 8'h00); // R9
   wire tx_role = mst_l_ff ? (addr_ph_ff | cfg_s.transmit) : (sel_ff & slv_tx_ff);
   wire frame_end = busy_l_ff & scl_fall & (cnt_ff == total);
   wire lost_now = busy_l_ff & scl_rise & mst_l_ff & (cnt_ff < nb) & tx_role
                   & sda_oe_n_ff & ~sda_s; // R15
   wire start_lost = (st_ff == L_IDLE) & start_req_ff & busy_l_ff; // R14
   wire irq_l = mst_l_ff | lostf_ff
                | (cfg_s.free_fmt ? 1'b1 : (addr_ph_ff ? (match | gcall) : sel_ff)); // R7 R8
   wire keep_l = lostf_ff & ~(match | gcall); // R13

   // data line drive for the next bit
   logic nxt_drive;
   always_comb begin
      nxt_drive = 1'b0;
      if (cnt_ff < nb) begin
         if (tx_role) nxt_drive = ~cfg_s.txd[3'(4'h7 - cnt_ff)];
      end else if (cnt_ff == nb) begin
         if (mst_l_ff) nxt_drive = ~addr_ph_ff & ~cfg_s.transmit & cfg_s.ack_en;
         else if (addr_ph_ff) nxt_drive = match | gcall; // R8
         else nxt_drive = sel_ff & ~slv_tx_ff & cfg_s.ack_en;
      end
      nxt_drive = nxt_drive & busy_l_ff;
   end

   // edge history and last bit
   always_ff @(posedge link_clk_i) begin
      if (lr) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         tgl_q_ff <= {start_s, stop_s, resume_s};
         lrb_l_ff <= 1'b0;
      end else begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
         tgl_q_ff <= {start_s, stop_s, resume_s};
         if (scl_rise) lrb_l_ff <= sda_s; // R20
      end
   end

   // transaction tracking: busy, bit count, shift, slave selection
   always_ff @(posedge link_clk_i) begin
      if (lr | stop_det) begin
         busy_l_ff <= 1'b0;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         addr_ph_ff <= 1'b0;
         sel_ff <= 1'b0;
         slv_tx_ff <= 1'b0;
         lostf_ff <= 1'b0;
      end else if (start_det) begin
         busy_l_ff <= 1'b1;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         addr_ph_ff <= 1'b1;
         sel_ff <= 1'b0;
         slv_tx_ff <= 1'b0;
         lostf_ff <= 1'b0;
      end else if (frame_end) begin
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         addr_ph_ff <= 1'b0;
         lostf_ff <= 1'b0;
         if (~mst_l_ff & addr_ph_ff) begin
            sel_ff <= cfg_s.free_fmt | match | gcall; // R18
            slv_tx_ff <= match & sh_ff[0];
         end
      end else if (busy_l_ff & scl_rise) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (cnt_ff < nb) sh_ff <= {sh_ff[6:0], sda_s};
         if (lost_now) lostf_ff <= 1'b1;
      end
   end

   // service hold of the clock line and low time before release
   always_ff @(posedge link_clk_i) begin
      if (lr) begin
         hold_ff <= 1'b0;
         rel_cnt_ff <= 8'h00;
      end else if (frame_end & irq_l & ~keep_l) begin
         hold_ff <= 1'b1; // R10
      end else if (hold_ff & res_edge) begin
         hold_ff <= 1'b0;
         rel_cnt_ff <= `TLOW_CYC; // R11
      end else if (rel_cnt_ff != 8'h00) begin
         rel_cnt_ff <= rel_cnt_ff - 8'h01;
      end
   end

   // event payload toward the core
   always_ff @(posedge link_clk_i) begin
      if (lr) begin
         evt_ff <= '0;
         evt_tgl_ff <= 1'b0;
      end else if (start_det | stop_det | frame_end | lost_now | start_lost) begin
         evt_ff <= '{start_seen: start_det, stop_seen: stop_det,
                     lost: lost_now | start_lost, frame: frame_end,
                     irq: irq_l, keep_pin: keep_l, addr_phase: addr_ph_ff,
                     match: match, gcall: gcall, rw: sh_ff[0], master_select: mst_l_ff,
                     last_bit: lrb_l_ff, data: sh_ff};
         evt_tgl_ff <= ~evt_tgl_ff;
      end
   end

   // pending start and stop requests
   always_ff @(posedge link_clk_i) begin
      if (lr) begin
         start_req_ff <= 1'b0;
         stop_req_ff <= 1'b0;
      end else begin
         if (start_s ^ tgl_q_ff[2]) start_req_ff <= 1'b1;
         else if (st_ff == L_IDLE) start_req_ff <= 1'b0;
         if (stop_s ^ tgl_q_ff[1]) stop_req_ff <= 1'b1;
         else if ((st_ff == L_HOLD) | ~mst_l_ff) stop_req_ff <= 1'b0;
      end
   end

   // master sequencer
   wire ph_done = (ph_ff == `HALF_CYC);
   always_ff @(posedge link_clk_i) begin
      if (lr) begin
         st_ff <= L_IDLE;
         ph_ff <= 8'h00;
         mst_l_ff <= 1'b0;
      end else if (lost_now | stop_det) begin
         st_ff <= L_IDLE; // R16
         ph_ff <= 8'h00;
         mst_l_ff <= 1'b0;
      end else begin
         case (st_ff)
            L_IDLE: begin
               ph_ff <= 8'h00;
               if (start_req_ff & ~busy_l_ff) st_ff <= L_START; // R1 R14
            end
            L_START: begin
               ph_ff <= ph_ff + 8'h01;
               if (ph_done) begin
                  st_ff <= L_LOW;
                  ph_ff <= 8'h00;
                  mst_l_ff <= 1'b1;
               end
            end
            L_LOW: begin
               ph_ff <= ph_ff + 8'h01;
               if (ph_done) begin
                  st_ff <= L_HIGH;
                  ph_ff <= 8'h00;
               end
            end
            L_HIGH: begin
               if (scl_s) ph_ff <= ph_ff + 8'h01;
               if (ph_done) begin
                  st_ff <= (cnt_ff == total) ? L_HOLD : L_LOW; // R7
                  ph_ff <= 8'h00;
               end
            end
            L_HOLD: begin
               if (stop_req_ff) st_ff <= L_STOP1; // R3
               else if (rel_cnt_ff == 8'h01) st_ff <= L_HIGH; // R11
            end
            L_STOP1: begin
               ph_ff <= ph_ff + 8'h01;
               if (ph_done) begin
                  st_ff <= L_STOP2;
                  ph_ff <= 8'h00;
               end
            end
            L_STOP2: begin
               if (scl_s) ph_ff <= ph_ff + 8'h01; // R5
               if (ph_done) begin
                  st_ff <= L_STOP3;
                  ph_ff <= 8'h00;
               end
            end
            L_STOP3: begin
               ph_ff <= ph_ff + 8'h01;
               if (ph_done) begin
                  st_ff <= L_IDLE;
                  ph_ff <= 8'h00;
                  mst_l_ff <= 1'b0;
               end
            end
            default: st_ff <= L_IDLE;
         endcase
      end
   end

   // pin drivers: pull low or release only
   wire scl_low = (st_ff == L_LOW) | (st_ff == L_HOLD) | (st_ff == L_STOP1)
                  | (~mst_l_ff & (hold_ff | (rel_cnt_ff != 8'h00))); // R10
   always_ff @(posedge link_clk_i) begin
      if (lr) begin
         scl_oe_n_ff <= 1'b1;
         sda_oe_n_ff <= 1'b1;
         zero_ff <= 1'b0;
      end else begin
         zero_ff <= 1'b0; // R25
         scl_oe_n_ff <= ~scl_low;
         if (lost_now) sda_oe_n_ff <= 1'b1; // R16
         else if ((st_ff == L_START) | (st_ff == L_STOP1) | (st_ff == L_STOP2))
            sda_oe_n_ff <= 1'b0;
         else if (st_ff == L_STOP3) sda_oe_n_ff <= 1'b1;
         else if (~scl_s) sda_oe_n_ff <= ~nxt_drive;
      end
   end

   assign scl_o = zero_ff;
   assign sda_o = zero_ff;
   assign scl_oe_n_o = scl_oe_n_ff;
   assign sda_oe_n_o = sda_oe_n_ff;
endmodule

// ==== verif/i2c_ctrl_assertions.sv ====
// Purpose: port checks of the bus controller
// Assumes: one core clock domain
// Notes: bus lines sampled on the core clock
`timescale 1ns/1ns
module i2c_ctrl_assertions (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic cr2_wr_i,
   input wire i2c_ctrl_pkg::cr2_wr_t cr2_wdata_i,
   input wire logic dbr_wr_i,
   input wire logic dbr_rd_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire i2c_ctrl_pkg::status_t status_o,
   input wire logic irq_o
);
   import i2c_ctrl_pkg::*;
   logic acc;
   logic bad;
   logic zw;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // buffer access, start on busy bus, plain zero write to service bit
   assign acc = dbr_wr_i || dbr_rd_i;
   assign bad = cr2_wr_i && status_o.busy && cr2_wdata_i[7:4] == 4'hF;
   assign zw = cr2_wr_i && !cr2_wdata_i.pending_n && !acc && cr2_wdata_i.soft_init == 2'h0;
   // ===========================================
   // service bit, flags and bus state
   a_irq_pin_low: assert property (irq_o && !status_o.lost_arb |-> !status_o.pending_n)
      else $error("pin set at irq");
   a_access_sets_pin: assert property (acc |=> status_o.pending_n || irq_o)
      else $error("pin clear after access");
   a_zero_write_kept: assert property (zw && !status_o.pending_n |=> !status_o.pending_n)
      else $error("pin set by zero write");
   a_lost_cleared: assert property (acc || cr2_wr_i && !bad |=> !status_o.lost_arb)
      else $error("lost flag kept");
   a_refused_start: assert property (bad |=> status_o.lost_arb && !status_o.master)
      else $error("start on busy bus taken");
   a_aas_cleared: assert property (acc |=> !status_o.addressed) else $error("aas kept");
   a_busy_on_start: assert property ($fell(sda_i) && scl_i |-> ##[1:80] status_o.busy)
      else $error("busy not set");
   a_free_on_stop: assert property ($rose(sda_i) && scl_i |-> ##[1:80] !status_o.busy)
      else $error("busy not cleared");
   // main scenarios
   c_irq: cover property (irq_o);
   c_lost: cover property ($rose(status_o.lost_arb));
   c_gcall: cover property ($rose(status_o.gcall));
endmodule
bind i2c_ctrl i2c_ctrl_assertions i2c_ctrl_assertions_i (.core_clk_i, .rst_i, .cr2_wr_i,
   .cr2_wdata_i, .dbr_wr_i, .dbr_rd_i, .scl_i, .sda_i, .status_o, .irq_o);

// ==== verif/i2c_bus_peer.sv ====
// Purpose: far-side bus peer, slave and second master
// Assumes: pull-ups on both lines
// Notes: master side driven by bench task calls
`timescale 1ns/1ns
module i2c_bus_peer #(
   parameter logic [6:0] ADR = 7'h2B,
   parameter int T = 2500
) (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_n_o,
   output logic sda_oe_n_o
);
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   logic ack_n = 1'b1;
   logic [7:0] sh = 8'h00;
   int bits = 0;
   // ===========================================
   // lines only pulled low or released
   assign scl_oe_n_o = m_scl;
   assign sda_oe_n_o = m_sda & ack_n;
   // slave: count clocks from start, ack own address on ninth
   always @(negedge sda_i) if (scl_i) bits = 0;
   always @(posedge scl_i) begin
      sh = {sh[6:0], sda_i};
      bits++;
   end
   always @(negedge scl_i) ack_n <= #200 !(bits == 8 && sh[7:1] == ADR);
   // one clock, waits while another device stretches it
   task automatic bit_out(input logic b);
      #(T / 2) m_sda = b;
      #(T / 2) m_scl = 1'b1;
      wait (scl_i);
      #T m_scl = 1'b0;
   endtask
   // start, eight bits msb first, released ninth bit
   task automatic send_byte(input logic [7:0] d);
      m_sda = 1'b0;
      #T m_scl = 1'b0;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_out(1'b1);
   endtask
   task automatic send_stop();
      #T m_sda = 1'b0;
      #T m_scl = 1'b1;
      wait (scl_i);
      #T m_sda = 1'b1;
   endtask
endmodule

// ==== verif/i2c_ctrl_bench.sv ====
// Purpose: directed bench of the bus controller
// Assumes: pull-ups, peer model on the far side
// Notes: status compared as one byte, busy in bit 7
`timescale 1ns/1ns
module i2c_ctrl_bench;
   import i2c_ctrl_pkg::*;
   logic core_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cr2_wr_i = 1'b0;
   cr2_wr_t cr2_wdata_i = 8'h00;
   logic dbr_wr_i = 1'b0;
   logic dbr_rd_i = 1'b0;
   logic [7:0] dbr_wdata_i = 8'h00;
   logic [2:0] bit_count_i = 3'h3;
   logic scl_oe_n_o, sda_oe_n_o, p_scl, p_sda, irq_o;
   logic [1:0] soft_init_o, iface_mode_o;
   status_t status_o;
   wire logic scl_w = scl_oe_n_o & p_scl;
   wire logic sda_w = sda_oe_n_o & p_sda;
   logic [7:0] irq_cnt = 8'h00, rx_data_o;
   logic [7:0] rises = 8'h00;
   logic [7:0] n = 8'h02;
   logic [7:0] adr [3] = '{8'h6A, 8'h00, 8'h22};
   logic [7:0] ex [3] = '{8'h84, 8'h86, 8'h91};
   int fail_count = 0;
   int checks_done = 0;
   // ===========================================
   // clocks and event counters
   always #5 core_clk_i = ~core_clk_i;
   always begin
      #62 link_clk_i = 1'b1;
      #63 link_clk_i = 1'b0;
   end
   always @(posedge core_clk_i) if (irq_o === 1'b1) irq_cnt <= irq_cnt + 8'h01;
   always @(posedge scl_w) rises++;
   i2c_ctrl i2c_ctrl_i (.core_clk_i, .rst_i, .link_clk_i, .cr2_wr_i, .cr2_wdata_i, .dbr_wr_i,
      .dbr_wdata_i, .dbr_rd_i, .ack_en_i(1'b1), .bit_count_i, .own_addr_i(7'h35),
      .free_format_i(1'b0), .idle_run_en_i(1'b1), .idle_mode_i(1'b0), .scl_i(scl_w),
      .sda_i(sda_w), .scl_o(), .scl_oe_n_o, .sda_o(), .sda_oe_n_o, .status_o, .rx_data_o,
      .soft_init_o, .iface_mode_o, .irq_o);
   i2c_bus_peer i2c_bus_peer_i (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_n_o(p_scl),
      .sda_oe_n_o(p_sda));
   // ===========================================
   // tasks
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one-cycle pulse of control write, buffer write or buffer read
   task automatic req(input logic [2:0] k, input logic [7:0] d);
      @(posedge core_clk_i);
      #1 {cr2_wr_i, dbr_wr_i, dbr_rd_i} = k;
      cr2_wdata_i = d;
      dbr_wdata_i = d;
      @(posedge core_clk_i);
      #1 {cr2_wr_i, dbr_wr_i, dbr_rd_i} = 3'h0;
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wait_irq(input logic [7:0] k);
      for (int i = 0; i < 20000 && irq_cnt < k; i++) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wait_free();
      for (int i = 0; i < 20000 && status_o.busy !== 1'b0; i++) @(posedge core_clk_i);
      #1;
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #800000;
      fail_count++;
      finish_test();
   end
   // ===========================================
   // sequence
   initial begin
      repeat (2) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      req(3'h4, 8'h12);
      chk("reset status", 8'h10, status_o);
      repeat (150) @(posedge core_clk_i);
      // master start, address forced to eight bits plus acknowledge
      req(3'h2, 8'h56);
      rises = 8'h00;
      req(3'h4, 8'hF2);
      wait_irq(8'h01);
      chk("addr clocks", 8'h09, rises);
      chk("addr status", 8'hE0, status_o);
      rises = 8'h00;
      req(3'h2, 8'hA0);
      wait_irq(8'h02);
      chk("data clocks", 8'h04, rises);
      // zero to the service bit keeps the clock held low
      req(3'h4, 8'hE2);
      repeat (1000) @(posedge core_clk_i);
      chk("held status", 8'hE1, status_o);
      chk("held clock", 8'h00, {7'h0, scl_w});
      req(3'h4, 8'hD2);
      wait_free();
      chk("stop status", 8'h10, status_o);
      // second master: own address, general call, foreign address
      for (int i = 0; i < 3; i++) begin
         i2c_bus_peer_i.send_byte(adr[i]);
         repeat (200) @(posedge core_clk_i);
         n = n + {7'h0, i < 2};
         chk("slave irqs", n, irq_cnt);
         chk("slave status", ex[i], status_o);
         chk("rx byte", adr[i], rx_data_o);
         req(3'h4, 8'hF2);
         chk("refused start", ex[i] | 8'h18, status_o);
         req(3'h1, 8'h00);
         chk("after read", ex[i] & 8'hF3 | 8'h10, status_o);
         i2c_bus_peer_i.send_stop();
         wait_free();
         chk("free status", 8'h10, status_o);
      end
      req(3'h4, 8'h1A);
      req(3'h4, 8'h16);
      chk("mode fields", 8'h00, {4'h0, soft_init_o, iface_mode_o});
      chk("soft status", 8'h10, status_o);
      finish_test();
   end
endmodule
